// ### rtl/aem_pkg.sv
/*
  Constants, types and helpers for the add-only EPROM memory-function logic.
  Assumes one clock domain and a byte/slot level link layer outside the block.
*/
package aem_pkg;
  localparam int DATA_PAGES = 256;
  localparam int PAGE_BYTES = 32;
  localparam int DATA_AW = 13;
  localparam logic [12:0] DATA_LAST = 13'h1fff;
  localparam logic [7:0] CMD_READ_DATA = 8'hf0;
  localparam logic [7:0] CMD_READ_STAT = 8'haa;
  localparam logic [7:0] CMD_WRITE_DATA = 8'h0f;
  localparam logic [7:0] CMD_WRITE_STAT = 8'h55;
  localparam logic [15:0] STAT_FLAG_LAST = 16'h005f;
  localparam logic [15:0] STAT_REDIR_BASE = 16'h0100;
  localparam logic [15:0] STAT_REDIR_LAST = 16'h01ff;
  localparam logic [8:0] STAT_RWP_INDEX = 9'h020;
  localparam logic [8:0] STAT_LOW_BYTES = 9'h060;
  localparam int STAT_BYTES = 352;
  localparam logic [2:0] STAT_PAGE_LAST = 3'h7;
  localparam logic [2:0] BYTE_BITS_M1 = 3'h7;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_CLEAR = 16'h0000;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] SCRATCH_CLEAR = 8'h00;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [15:0] {
    S_IDLE = 16'h0001,
    S_CMD = 16'h0002,
    S_ADL = 16'h0004,
    S_ADH = 16'h0008,
    S_RDWAIT = 16'h0010,
    S_RDPUSH = 16'h0020,
    S_CRCL = 16'h0040,
    S_CRCH = 16'h0080,
    S_ONES = 16'h0100,
    S_WDATA = 16'h0200,
    S_WPROG = 16'h0400,
    S_WSET = 16'h0800,
    S_WHOLD = 16'h1000,
    S_WVER = 16'h2000
  } aem_state_t;

  // Reflected CRC16, x16+x15+x2+1, bits entered LSB first
  function automatic logic [15:0] aem_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ b[i];
      c = {1'b0, c[15:1]};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : aem_crc_byte

  function automatic logic aem_stat_present(input logic [15:0] a);
    return (a <= STAT_FLAG_LAST) || ((a >= STAT_REDIR_BASE) && (a <= STAT_REDIR_LAST));
  endfunction : aem_stat_present

  function automatic logic [8:0] aem_stat_index(input logic [15:0] a);
    if (a <= STAT_FLAG_LAST) begin
      return {2'b00, a[6:0]};
    end
    return STAT_LOW_BYTES + {1'b0, a[7:0]};
  endfunction : aem_stat_index
endpackage : aem_pkg

// ### rtl/aem_byte_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module aem_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  wire do_push = in_valid_in && in_ready_out;
  wire do_pop = out_valid_out && out_ready_in;

  assign in_ready_out = (count_q != FULL_COUNT);
  assign out_valid_out = (count_q != '0);
  assign out_data_out = mem_q[rd_q];

  always_ff @(posedge clk_in) begin
    if (rst_in || flush_in) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end
endmodule : aem_byte_fifo
`default_nettype wire

// ### rtl/aem_memfunc.sv
/*
  Memory-function logic of an add-only EPROM token: command decode, data and
  status reads with CRC16, byte programming through a scratchpad.
  Assumes a link layer that delivers received bytes, read-slot pulses, the
  bus reset pulse, the programming-voltage pulse and a ROM-stage-done pulse,
  and an external data EPROM array with registered read.
*/
// Contract
// - Data memory is 256 pages of 32 bytes
// - Scratchpad byte, CRC checked, then programming pulse commits
// - Page write-protect bits block data page programming
// - Redirection protect bits block redirection byte changes
// - Page-in-use flags are plain storage only
// - Redirection bytes stored, never steer logic
// - Unimplemented status reads FFH, writes ignored
// - Programming only clears bits to zero
// - Writes byte by byte, each committed by programming pulse
// - Reads auto-increment until field end or reset
// - All bytes shifted least significant bit first
// - F0H reads data, low then high address
// - Data end sends CRC16 over whole read
// - After data CRC, read slots return ones
// - Reset before data end gives no CRC
// - AAH reads status to page end, then CRC16
// - Status page ends at low digit 7/F
// - Later status pages restart CRC at page
// - 2816 status bits through separate commands
// - After last status CRC, slots return ones
// - Commands accepted only after ROM stage done
`timescale 1ns/1ns
`default_nettype none
module aem_memfunc #(
  parameter int FIFO_DEPTH = aem_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic bus_reset_in,
  input wire logic rom_done_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic slot_in,
  input wire logic prog_pulse_in,
  input wire logic [7:0] mem_rdata_in,
  output logic tx_bit_out,
  output logic [12:0] mem_addr_out,
  output logic mem_we_out,
  output logic [7:0] mem_wdata_out,
  output logic active_out
);
  aem_pkg::aem_state_t state_q;
  aem_pkg::aem_state_t state_d;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic [7:0] scratch_q;
  logic [7:0] scratch_d;
  logic [7:0] stat_q [aem_pkg::STAT_BYTES];
  logic stat_we_d;
  logic mem_we_d;
  logic [7:0] sh_q;
  logic [2:0] left_q;
  logic tx_bit_q;
  logic [12:0] mem_addr_q;
  logic mem_we_q;
  logic [7:0] mem_wdata_q;
  logic active_q;

  // Decoding of the current command and address
  wire is_stat = (cmd_q == aem_pkg::CMD_READ_STAT) || (cmd_q == aem_pkg::CMD_WRITE_STAT);
  wire is_write = (cmd_q == aem_pkg::CMD_WRITE_DATA) || (cmd_q == aem_pkg::CMD_WRITE_STAT);
  wire stat_here = aem_pkg::aem_stat_present(addr_q);
  wire [8:0] stat_idx = aem_pkg::aem_stat_index(addr_q);
  wire [7:0] stat_rd = stat_here ? stat_q[stat_idx] : aem_pkg::ERASED;
  wire [7:0] rd_byte = is_stat ? stat_rd : mem_rdata_in;
  wire [7:0] page = addr_q[12:5];
  wire [7:0] wp_byte = stat_q[{4'h0, page[7:3]}];
  wire page_wp = !wp_byte[page[2:0]];
  wire is_redir = (addr_q >= aem_pkg::STAT_REDIR_BASE) && (addr_q <= aem_pkg::STAT_REDIR_LAST);
  wire [7:0] rwp_byte = stat_q[aem_pkg::STAT_RWP_INDEX + {4'h0, addr_q[7:3]}];
  wire redir_wp = is_redir && !rwp_byte[addr_q[2:0]];
  wire data_end = (addr_q[12:0] == aem_pkg::DATA_LAST);
  wire stat_end = (addr_q[2:0] == aem_pkg::STAT_PAGE_LAST);
  wire stat_last = (addr_q >= aem_pkg::STAT_REDIR_LAST);
  wire [15:0] addr_inc = is_stat ? addr_q + 16'h0001 : {3'b000, addr_q[12:0] + 13'h0001};

  // Byte stream into the FIFO
  wire push_valid = (state_q == aem_pkg::S_RDPUSH) || (state_q == aem_pkg::S_CRCL)
                 || (state_q == aem_pkg::S_CRCH) || (state_q == aem_pkg::S_WVER);
  wire [7:0] push_data = (state_q == aem_pkg::S_CRCL) ? crc_q[7:0]
                       : (state_q == aem_pkg::S_CRCH) ? crc_q[15:8] : rd_byte;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire pushed = push_valid && fifo_in_ready;
  wire pop = slot_in && (left_q == '0) && fifo_out_valid;

  aem_byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(bus_reset_in),
    .in_valid_in(push_valid),
    .in_data_in(push_data),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(pop)
  );

  // Command sequencer
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    crc_d = crc_q;
    scratch_d = scratch_q;
    stat_we_d = 1'b0;
    mem_we_d = 1'b0;
    case (state_q)
      aem_pkg::S_IDLE: begin
        if (rom_done_in) begin
          state_d = aem_pkg::S_CMD;
        end
      end
      aem_pkg::S_CMD: begin
        if (rx_valid_in) begin
          cmd_d = rx_byte_in;
          crc_d = aem_pkg::aem_crc_byte(aem_pkg::CRC_CLEAR, rx_byte_in);
          case (rx_byte_in)
            aem_pkg::CMD_READ_DATA, aem_pkg::CMD_READ_STAT,
            aem_pkg::CMD_WRITE_DATA, aem_pkg::CMD_WRITE_STAT: begin
              state_d = aem_pkg::S_ADL;
            end
            default: begin
              state_d = aem_pkg::S_ONES;
            end
          endcase
        end
      end
      aem_pkg::S_ADL: begin
        if (rx_valid_in) begin
          addr_d = {addr_q[15:8], rx_byte_in};
          crc_d = aem_pkg::aem_crc_byte(crc_q, rx_byte_in);
          state_d = aem_pkg::S_ADH;
        end
      end
      aem_pkg::S_ADH: begin
        if (rx_valid_in) begin
          addr_d = {rx_byte_in, addr_q[7:0]};
          if (!is_stat) begin
            addr_d[15:13] = 3'b000;
          end
          crc_d = aem_pkg::aem_crc_byte(crc_q, rx_byte_in);
          state_d = is_write ? aem_pkg::S_WDATA : aem_pkg::S_RDWAIT;
        end
      end
      aem_pkg::S_RDWAIT: begin
        state_d = aem_pkg::S_RDPUSH;
      end
      aem_pkg::S_RDPUSH: begin
        if (pushed) begin
          crc_d = aem_pkg::aem_crc_byte(crc_q, rd_byte);
          if (is_stat ? stat_end : data_end) begin
            state_d = aem_pkg::S_CRCL;
          end else begin
            addr_d = addr_inc;
            state_d = aem_pkg::S_RDWAIT;
          end
        end
      end
      aem_pkg::S_CRCL: begin
        if (pushed) begin
          state_d = aem_pkg::S_CRCH;
        end
      end
      aem_pkg::S_CRCH: begin
        if (pushed) begin
          if (is_write) begin
            state_d = aem_pkg::S_WPROG;
          end else if (!is_stat || stat_last) begin
            state_d = aem_pkg::S_ONES;
          end else begin
            crc_d = aem_pkg::CRC_CLEAR;
            addr_d = addr_inc;
            state_d = aem_pkg::S_RDWAIT;
          end
        end
      end
      aem_pkg::S_WDATA: begin
        if (rx_valid_in) begin
          scratch_d = rx_byte_in;
          crc_d = aem_pkg::aem_crc_byte(crc_q, rx_byte_in);
          state_d = aem_pkg::S_CRCL;
        end
      end
      aem_pkg::S_WPROG: begin
        if (prog_pulse_in) begin
          mem_we_d = !is_stat && !page_wp;
          stat_we_d = is_stat && stat_here && !redir_wp;
          state_d = aem_pkg::S_WSET;
        end
      end
      aem_pkg::S_WSET: begin
        state_d = aem_pkg::S_WHOLD;
      end
      aem_pkg::S_WHOLD: begin
        state_d = aem_pkg::S_WVER;
      end
      aem_pkg::S_WVER: begin
        if (pushed) begin
          addr_d = addr_inc;
          crc_d = aem_pkg::aem_crc_byte(aem_pkg::aem_crc_byte(aem_pkg::CRC_CLEAR, addr_inc[7:0]),
                                        addr_inc[15:8]);
          state_d = aem_pkg::S_WDATA;
        end
      end
      aem_pkg::S_ONES: begin
        state_d = aem_pkg::S_ONES;
      end
      default: begin
        state_d = aem_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || bus_reset_in) begin
      state_q <= aem_pkg::S_IDLE;
      cmd_q <= '0;
      addr_q <= '0;
      crc_q <= aem_pkg::CRC_CLEAR;
      scratch_q <= aem_pkg::SCRATCH_CLEAR;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      crc_q <= crc_d;
      scratch_q <= scratch_d;
    end
  end

  // Status memory: programming only clears bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < aem_pkg::STAT_BYTES; i++) begin
        stat_q[i] <= aem_pkg::ERASED;
      end
    end else if (stat_we_d) begin
      stat_q[stat_idx] <= stat_q[stat_idx] & scratch_q;
    end
  end

  // Data EPROM port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_addr_q <= '0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= aem_pkg::ERASED;
      active_q <= 1'b0;
    end else begin
      mem_addr_q <= addr_d[12:0];
      mem_we_q <= mem_we_d && !bus_reset_in;
      mem_wdata_q <= mem_rdata_in & scratch_q;
      active_q <= !bus_reset_in && (state_d != aem_pkg::S_IDLE)
               && (state_d != aem_pkg::S_ONES);
    end
  end

  // Read-slot serializer, LSB first, ones when nothing is queued
  always_ff @(posedge clk_in) begin
    if (rst_in || bus_reset_in) begin
      sh_q <= aem_pkg::ERASED;
      left_q <= '0;
      tx_bit_q <= 1'b1;
    end else if (slot_in) begin
      if (left_q != '0) begin
        tx_bit_q <= sh_q[0];
        sh_q <= {1'b1, sh_q[7:1]};
        left_q <= left_q - 3'h1;
      end else if (fifo_out_valid) begin
        tx_bit_q <= fifo_out_data[0];
        sh_q <= {1'b1, fifo_out_data[7:1]};
        left_q <= aem_pkg::BYTE_BITS_M1;
      end else begin
        tx_bit_q <= 1'b1;
      end
    end
  end

  assign tx_bit_out = tx_bit_q;
  assign mem_addr_out = mem_addr_q;
  assign mem_we_out = mem_we_q;
  assign mem_wdata_out = mem_wdata_q;
  assign active_out = active_q;

  a_ones_after_end: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == aem_pkg::S_ONES) && slot_in && (left_q == '0) && !fifo_out_valid
      && !bus_reset_in |=> tx_bit_out)
    else $error("idle read slot did not return one");

  a_rom_gate: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == aem_pkg::S_IDLE) && !rom_done_in |=> (state_q == aem_pkg::S_IDLE))
    else $error("command stage entered without ROM stage");

  a_reset_abort: assert property (
    @(posedge clk_in) disable iff (rst_in)
    bus_reset_in |=> (state_q == aem_pkg::S_IDLE) && (scratch_q == aem_pkg::SCRATCH_CLEAR)
      && !active_out)
    else $error("bus reset did not abort");

  a_page_protect: assert property (
    @(posedge clk_in) disable iff (rst_in)
    mem_we_out |-> !$past(page_wp) && $past(prog_pulse_in))
    else $error("protected page programmed");

  a_bits_clear_only: assert property (
    @(posedge clk_in) disable iff (rst_in)
    mem_we_out |-> ((mem_wdata_out & ~$past(mem_rdata_in, 2)) == 8'h00))
    else $error("programming set a bit");

  a_stat_page_crc: assert property (
    @(posedge clk_in) disable iff (rst_in || bus_reset_in)
    (state_q == aem_pkg::S_RDPUSH) && pushed && is_stat && stat_end
      |=> (state_q == aem_pkg::S_CRCL) ##0 (push_data == crc_q[7:0]))
    else $error("status page end without CRC");

  a_data_end_crc: assert property (
    @(posedge clk_in) disable iff (rst_in || bus_reset_in)
    (state_q == aem_pkg::S_RDPUSH) && pushed && !is_stat && data_end
      |=> (state_q == aem_pkg::S_CRCL))
    else $error("data end without CRC");

  a_page_crc_clear: assert property (
    @(posedge clk_in) disable iff (rst_in || bus_reset_in)
    (state_q == aem_pkg::S_CRCH) && pushed && is_stat && !is_write && !stat_last
      |=> (crc_q == aem_pkg::CRC_CLEAR) ##1 (crc_q == aem_pkg::CRC_CLEAR)
      && (state_q == aem_pkg::S_RDPUSH))
    else $error("status CRC not restarted");

  a_unimpl_reads_ff: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == aem_pkg::S_RDPUSH) && is_stat && !stat_here |-> (push_data == aem_pkg::ERASED))
    else $error("unimplemented status byte not FFH");

  a_lsb_first: assert property (
    @(posedge clk_in) disable iff (rst_in || bus_reset_in)
    pop |=> (tx_bit_out == $past(fifo_out_data[0])) ##0 (left_q == aem_pkg::BYTE_BITS_M1))
    else $error("byte not sent LSB first");
endmodule : aem_memfunc
`default_nettype wire

// ### verif/aem_master_model.sv
/*
  Byte and slot level model of the bus master facing the memory functions.
  Assumes the bench calls its tasks from one process and shares its clock.
*/
`timescale 1ns/1ns
`default_nettype none
module aem_master_model (
  input wire logic clk_in,
  input wire logic tx_bit_in,
  output logic bus_reset_out,
  output logic rom_done_out,
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out,
  output logic slot_out,
  output logic prog_pulse_out
);
  initial begin
    bus_reset_out = 1'b0;
    rom_done_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h00;
    slot_out = 1'b0;
    prog_pulse_out = 1'b0;
  end

  // One-cycle pulse: bit 2 bus reset, bit 1 ROM stage done, bit 0 programming voltage
  task automatic strobe(input logic [2:0] sel);
    @(posedge clk_in);
    {bus_reset_out, rom_done_out, prog_pulse_out} <= sel;
    @(posedge clk_in);
    {bus_reset_out, rom_done_out, prog_pulse_out} <= 3'h0;
  endtask : strobe

  // Released byte lines show the inverse of the last value
  task automatic send(input logic [7:0] b);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_byte_out <= b;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~b;
  endtask : send

  // Eight read slots, first bit is the least significant
  task automatic get(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      slot_out <= 1'b1;
      @(posedge clk_in);
      slot_out <= 1'b0;
      @(negedge clk_in);
      b[i] = tx_bit_in;
      repeat (6) @(posedge clk_in);
    end
  endtask : get
endmodule : aem_master_model
`default_nettype wire

// ### verif/addonly_eprom_memory_functions_test.sv
/*
  Self-checking bench for the memory-function block: writes, data and status reads.
  Assumes the master model above and a registered-read data array kept here.
*/
`timescale 1ns/1ns
`default_nettype none
module addonly_eprom_memory_functions_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic bus_reset, rom_done, rx_valid, slot, prog_pulse, tx_bit, mem_we, active;
  logic [7:0] rx_byte, mem_wdata, we_data;
  logic [7:0] mem_rdata = 8'hff;
  logic [12:0] mem_addr, we_addr;
  logic [7:0] mem [8192];
  logic [15:0] crc;
  int we_cnt = 0;
  int n_fail = 0;
  int total_checks = 0;

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  aem_memfunc aem_memfunc_i (.clk_in(clk_in), .rst_in(rst_in), .bus_reset_in(bus_reset),
    .rom_done_in(rom_done), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .slot_in(slot),
    .prog_pulse_in(prog_pulse), .mem_rdata_in(mem_rdata), .tx_bit_out(tx_bit),
    .mem_addr_out(mem_addr), .mem_we_out(mem_we), .mem_wdata_out(mem_wdata),
    .active_out(active));

  aem_master_model aem_master_model_i (.clk_in(clk_in), .tx_bit_in(tx_bit),
    .bus_reset_out(bus_reset), .rom_done_out(rom_done), .rx_valid_out(rx_valid),
    .rx_byte_out(rx_byte), .slot_out(slot), .prog_pulse_out(prog_pulse));

  // Data array, erased except one preset byte to show bits only clear
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem[13'h1fff] = 8'h3c;
  end

  always @(posedge clk_in) begin
    if (mem_we === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
      we_cnt <= we_cnt + 1;
      we_addr <= mem_addr;
      we_data <= mem_wdata;
    end
    mem_rdata <= mem[mem_addr];
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ b[i];
      c = {1'b0, c[15:1]};
      if (fb) begin
        c = c ^ 16'ha001;
      end
    end
    return c;
  endfunction : crc_step

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic rd_exp(input string what, input logic [7:0] e);
    logic [7:0] b;
    aem_master_model_i.get(b);
    crc = crc_step(crc, e);
    chk_val(what, {8'h00, e}, {8'h00, b});
  endtask : rd_exp

  task automatic crc_exp(input string what);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] e;
    e = crc;
    aem_master_model_i.get(lo);
    aem_master_model_i.get(hi);
    chk_val(what, e, {hi, lo});
  endtask : crc_exp

  task automatic fresh;
    aem_master_model_i.strobe(3'h4);
    aem_master_model_i.strobe(3'h2);
  endtask : fresh

  task automatic cmd3(input logic [7:0] c, input logic [15:0] a);
    crc = crc_step(crc_step(crc_step(16'h0000, c), a[7:0]), a[15:8]);
    aem_master_model_i.send(c);
    aem_master_model_i.send(a[7:0]);
    aem_master_model_i.send(a[15:8]);
    repeat (8) @(posedge clk_in);
  endtask : cmd3

  // Data byte, its CRC, then the programming pulse
  task automatic wr_byte(input logic [7:0] d);
    aem_master_model_i.send(d);
    crc = crc_step(crc, d);
    repeat (8) @(posedge clk_in);
    crc_exp("write crc");
    aem_master_model_i.strobe(3'h1);
    repeat (8) @(posedge clk_in);
  endtask : wr_byte

  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end

  initial begin
    int n;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk_bit("idle tx", 1'b1, tx_bit);
    chk_bit("idle we", 1'b0, mem_we);
    cmd3(8'hf0, 16'h0000);
    chk_bit("active early", 1'b0, active);
    rd_exp("early slot", 8'hff);
    $display("test reset done");

    fresh();
    cmd3(8'h0f, 16'h1ffe);
    wr_byte(8'h5a);
    chk_val("we count", 16'd1, we_cnt[15:0]);
    chk_val("we addr", {3'h0, 13'h1ffe}, {3'h0, we_addr});
    rd_exp("verify", 8'h5a);
    crc = crc_step(crc_step(16'h0000, 8'hff), 8'h1f);
    wr_byte(8'h0f);
    chk_val("we data", 16'h000c, {8'h00, we_data});
    rd_exp("verify and", 8'h0c);
    $display("test data write done");

    fresh();
    cmd3(8'hf0, 16'h1ffe);
    rd_exp("data 1ffe", 8'h5a);
    rd_exp("data 1fff", 8'h0c);
    crc_exp("data crc");
    rd_exp("after crc", 8'hff);
    $display("test data read done");

    fresh();
    cmd3(8'h55, 16'h0000);
    wr_byte(8'hfe);
    rd_exp("status verify", 8'hfe);
    fresh();
    cmd3(8'h55, 16'h0060);
    wr_byte(8'h00);
    fresh();
    cmd3(8'h55, 16'h01ff);
    wr_byte(8'hfd);
    fresh();
    n = we_cnt;
    cmd3(8'h0f, 16'h0005);
    wr_byte(8'h00);
    chk_val("protected we", n[15:0], we_cnt[15:0]);
    $display("test protect done");

    fresh();
    cmd3(8'haa, 16'h005e);
    chk_bit("active read", 1'b1, active);
    rd_exp("flag 05e", 8'hff);
    rd_exp("flag 05f", 8'hff);
    crc_exp("status crc");
    crc = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      rd_exp("absent", 8'hff);
    end
    crc_exp("page crc");
    fresh();
    cmd3(8'haa, 16'h01ff);
    rd_exp("redirect", 8'hfd);
    crc_exp("last crc");
    rd_exp("after last", 8'hff);
    $display("test status read done");

    fresh();
    cmd3(8'hf0, 16'h1ffe);
    rd_exp("page 1ffe", 8'h5a);
    aem_master_model_i.strobe(3'h4);
    @(negedge clk_in);
    chk_bit("aborted", 1'b0, active);
    rd_exp("no crc", 8'hff);
    $display("test abort done");
    end_sim();
  end
endmodule : addonly_eprom_memory_functions_test
`default_nettype wire
